// ==== prs_pkg.sv ====
// Constants and types shared by the power-up reset sequencer files.
// Assumes a single 125 MHz system clock; all other clocks arrive as sampled inputs.
package prs_pkg;

  // ==========================================================================
  // Address map (program addresses and APB byte offsets).
  // ==========================================================================
  localparam logic [15:0] CFG_WORD_ADDR   = 16'h2007;
  localparam logic [15:0] CFG_WORD_OFFSET = 16'h801C;
  localparam logic [15:0] STATUS_OFFSET   = 16'h0000;
  localparam logic [15:0] CONTROL_OFFSET  = 16'h0004;
  localparam logic [15:0] TEST_SPACE_LO   = 16'h2000;
  localparam logic [15:0] TEST_SPACE_HI   = 16'h3FFF;
  localparam logic [12:0] RESET_VECTOR    = 13'h0000;

  // ==========================================================================
  // Configuration word fields.
  // ==========================================================================
  localparam int          CFG_WIDTH     = 14;
  localparam logic [13:0] CFG_ERASED    = 14'h3FFF;
  localparam int          CFG_OSC_LSB   = 0;
  localparam int          CFG_WDT_BIT   = 2;
  localparam int          CFG_POWERUP_DELAY_TIMER_BIT  = 3;
  localparam int          CFG_BOR_BIT   = 6;

  localparam logic [1:0] MODE_LOW_POWER  = 2'h0;
  localparam logic [1:0] MODE_CRYSTAL    = 2'h1;
  localparam logic [1:0] MODE_HIGH_SPEED = 2'h2;
  localparam logic [1:0] MODE_RC         = 2'h3;

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int POWERUP_DELAY_TIMER_TIME_MS     = 72;
  localparam int RC_TICK_HZ       = 14000;
  localparam int POWERUP_DELAY_TIMER_TICKS       = (POWERUP_DELAY_TIMER_TIME_MS * RC_TICK_HZ) / 1000;
  localparam int OST_CYCLES       = 1024;
  localparam int BOR_FILTER_NS    = 100;
  localparam int CLOCK_PERIOD_NS  = 8;
  localparam int BOR_FILTER_CYC   = (BOR_FILTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_POR   = 6'h01,
    ST_BOR   = 6'h02,
    ST_POWERUP_DELAY_TIMER  = 6'h04,
    ST_OST   = 6'h08,
    ST_RUN   = 6'h10,
    ST_SLEEP = 6'h20
  } prs_state_type;

  typedef struct packed {
    logic [1:0] osc_mode;
    logic       wdt_on;
    logic       powerup_delay_timer_on;
    logic       bor_on;
  } prs_cfg_type;

  function automatic prs_cfg_type decode_cfg(input logic [13:0] w);
    prs_cfg_type c;
    c.osc_mode = w[CFG_OSC_LSB +: 2];
    c.wdt_on   = w[CFG_WDT_BIT];
    c.powerup_delay_timer_on  = w[CFG_POWERUP_DELAY_TIMER_BIT];
    c.bor_on   = w[CFG_BOR_BIT];
    return c;
  endfunction

endpackage

// ==== prs_edge_counter.sv ====
// Counts rising edges of a sampled slow clock up to a terminal value.
// Assumes the slow clock is synchronous to CLOCK and slower than half its rate.
module prs_edge_counter #(
  parameter int WIDTH = 17
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             clear,
  input  wire logic             slow_clk,
  input  wire logic [WIDTH-1:0] terminal,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic             last_ff;
  logic             nxt_last;
  logic             done_ff;
  logic             nxt_done;

  // ==========================================================================
  // Counting.
  // ==========================================================================
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_last = slow_clk;
    nxt_done = done_ff;
    if (clear) begin
      nxt_cnt  = '0;
      nxt_done = 1'b0;
    end else if (slow_clk && !last_ff && !done_ff) begin
      nxt_cnt  = cnt_ff + 1'b1;
      nxt_done = (nxt_cnt >= terminal);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      last_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      last_ff <= nxt_last;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

// ==== prs_cfg_store.sv ====
// One-time-programmable configuration word store, erased to all ones.
// Assumes program_en is only raised by the programming interface.
module prs_cfg_store (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        program_en,
  input  wire logic [13:0] program_data,
  output logic      [13:0] rd_data
);

  logic [13:0] word_ff;
  logic [13:0] nxt_word;
  logic [13:0] rd_ff;

  // ==========================================================================
  // Programming clears bits only, as a fuse array would.
  // ==========================================================================
  always_comb begin
    nxt_word = word_ff;
    if (program_en) begin
      nxt_word = word_ff & program_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= prs_pkg::CFG_ERASED;
      rd_ff   <= prs_pkg::CFG_ERASED;
    end else if (ce) begin
      word_ff <= nxt_word;
      rd_ff   <= word_ff;
    end
  end

  assign rd_data = rd_ff;

endmodule

// ==== prs_sequencer.sv ====
// Power-up reset sequencer with an APB slave for the configuration word and status.
// Assumes all inputs are synchronous to CLOCK; the RC and main clocks are sampled.
// Operation
// - Configuration bits read 0 when programmed, 1 when erased.
// - Configuration word lives at program address 2007h.
// - Space 2000h to 3FFFh reachable only in programming mode.
// - Two select bits pick one of four oscillator modes.
// - Watchdog stopped only by its configuration bit, runs on own RC.
// - Sleep ends on external reset, watchdog wake-up or interrupt.
// - Power-on detect pulse resets and starts the power-up sequence.
// - Power-up delay of 72 ms runs after power-on detect and after brown-out reset.
// - Core reset held for the whole power-up delay.
// - Power-up delay counts internal RC clock ticks.
// - Enable bit for power-up delay; disabled skips it.
// - Start-up counter then holds reset for 1024 main clock cycles.
// - Start-up count only in crystal modes, on power-on or wake-up.
// - Brown-out enable bit: clear disables, set enables brown-out reset.
// - Brown-out dip longer than a minimum resets the device.
// - Hold brown-out reset while low, then add the 72 ms delay.
// - Brown-out during the delay re-enters reset and restarts the delay.
// - Core fetches from address 0000h after reset release.
//
// Design decision made here: the APB interface to the registers.
module prs_sequencer #(
  parameter int POWERUP_DELAY_TIMER_TICKS = prs_pkg::POWERUP_DELAY_TIMER_TICKS,
  parameter int OST_CYCLES = prs_pkg::OST_CYCLES,
  parameter int BOR_FILTER = prs_pkg::BOR_FILTER_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic        POWER_ON_DETECT,
  input  wire logic        BROWNOUT_DETECT,
  input  wire logic        EXTERNAL_RESET_PIN_N,
  input  wire logic        RC_CLOCK,
  input  wire logic        MAIN_CLOCK_INPUT_PIN,
  input  wire logic        SLEEP_REQ,
  input  wire logic        WATCHDOG_WAKE,
  input  wire logic        INTERRUPT_WAKE,
  input  wire logic        PROGRAMMING_MODE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             CORE_RESET,
  output logic      [12:0] FETCH_ADDR,
  output logic      [1:0]  OSC_MODE,
  output logic             WATCHDOG_RUN,
  output logic             SLEEPING
);

  prs_pkg::prs_state_type state_ff;
  prs_pkg::prs_state_type nxt_state;
  prs_pkg::prs_cfg_type   cfg;
  logic [13:0]            cfg_word;
  logic                   cfg_prog;
  logic                   powerup_delay_timer_clear;
  logic                   powerup_delay_timer_done;
  logic                   ost_clear;
  logic                   ost_done;
  logic [7:0]             bor_cnt_ff;
  logic [7:0]             nxt_bor_cnt;
  logic                   bor_trip;
  logic                   ost_need_ff;
  logic                   nxt_ost_need;
  logic                   apb_fire;
  logic [31:0]            nxt_prdata;
  logic                   nxt_pslverr;
  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic                   core_rst_ff;
  logic [1:0]             osc_ff;
  logic                   wdt_ff;
  logic                   sleep_ff;
  logic [12:0]            fetch_ff;

  // ==========================================================================
  // Configuration store.
  // ==========================================================================
  assign apb_fire = PSEL && PENABLE && !pready_ff;
  // Writes to the configuration word are only accepted while programming.
  assign cfg_prog = apb_fire && PWRITE && PROGRAMMING_MODE &&
                    (PADDR == prs_pkg::CFG_WORD_OFFSET);

  prs_cfg_store u_cfg (
    .clk          (CLOCK),
    .rst_n        (RSTN),
    .ce           (CE),
    .program_en   (cfg_prog),
    .program_data (PWDATA[13:0]),
    .rd_data      (cfg_word)
  );

  // Erased bits read 1, so every enable defaults on and the oscillator mode defaults to RC.
  assign cfg = prs_pkg::decode_cfg(cfg_word);

  // ==========================================================================
  // Timers.
  // ==========================================================================
  // The delay counts RC ticks; skipping it when disabled is handled by the FSM.
  prs_edge_counter #(.WIDTH(17)) u_powerup_delay_timer (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .ce       (CE),
    .clear    (powerup_delay_timer_clear),
    .slow_clk (RC_CLOCK),
    .terminal (17'(POWERUP_DELAY_TIMER_TICKS)),
    .done     (powerup_delay_timer_done)
  );

  // The start-up count watches the main clock pin.
  prs_edge_counter #(.WIDTH(17)) u_ost (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .ce       (CE),
    .clear    (ost_clear),
    .slow_clk (MAIN_CLOCK_INPUT_PIN),
    .terminal (17'(OST_CYCLES)),
    .done     (ost_done)
  );

  // ==========================================================================
  // Brown-out glitch filter.
  // ==========================================================================
  // Short dips never reach the trip count, so they are ignored.
  always_comb begin
    nxt_bor_cnt = 8'h00;
    if (BROWNOUT_DETECT && cfg.bor_on) begin
      nxt_bor_cnt = (bor_cnt_ff == 8'(BOR_FILTER)) ? bor_cnt_ff : bor_cnt_ff + 8'h01;
    end
  end
  assign bor_trip = cfg.bor_on && BROWNOUT_DETECT && (bor_cnt_ff == 8'(BOR_FILTER));

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bor_cnt_ff <= 8'h00;
    end else if (CE) begin
      bor_cnt_ff <= nxt_bor_cnt;
    end
  end

  // ==========================================================================
  // Sequencing state machine.
  // ==========================================================================
  always_comb begin
    nxt_state    = state_ff;
    nxt_ost_need = ost_need_ff;
    powerup_delay_timer_clear   = 1'b0;
    ost_clear    = 1'b0;
    if (POWER_ON_DETECT) begin
      nxt_state    = prs_pkg::ST_POR;
      nxt_ost_need = 1'b1;
      powerup_delay_timer_clear   = 1'b1;
      ost_clear    = 1'b1;
    end else if (bor_trip && state_ff != prs_pkg::ST_BOR) begin
      nxt_state  = prs_pkg::ST_BOR;
      powerup_delay_timer_clear = 1'b1;
      ost_clear  = 1'b1;
    end else begin
      case (state_ff)
        prs_pkg::ST_POR: begin
          // Delay is skipped when its enable bit is programmed.
          nxt_state = cfg.powerup_delay_timer_on ? prs_pkg::ST_POWERUP_DELAY_TIMER : prs_pkg::ST_OST;
        end
        prs_pkg::ST_BOR: begin
          powerup_delay_timer_clear = 1'b1;
          ost_clear  = 1'b1;
          // Stay while supply is low, then run the full delay again.
          if (!BROWNOUT_DETECT) begin
            nxt_state = cfg.powerup_delay_timer_on ? prs_pkg::ST_POWERUP_DELAY_TIMER : prs_pkg::ST_OST;
          end
        end
        prs_pkg::ST_POWERUP_DELAY_TIMER: begin
          if (powerup_delay_timer_done) begin
            nxt_state = prs_pkg::ST_OST;
          end
        end
        prs_pkg::ST_OST: begin
          // Only crystal modes after power-on or wake-up need the count.
          // A held external reset pin keeps the core here until it is released.
          if (EXTERNAL_RESET_PIN_N &&
              (cfg.osc_mode == prs_pkg::MODE_RC || !ost_need_ff || ost_done)) begin
            nxt_state    = prs_pkg::ST_RUN;
            nxt_ost_need = 1'b0;
          end
        end
        prs_pkg::ST_RUN: begin
          if (!EXTERNAL_RESET_PIN_N) begin
            nxt_state = prs_pkg::ST_OST;
            ost_clear = 1'b1;
          end else if (SLEEP_REQ) begin
            nxt_state = prs_pkg::ST_SLEEP;
          end
        end
        prs_pkg::ST_SLEEP: begin
          // Wake sources end sleep; wake-up runs the start-up count.
          if (!EXTERNAL_RESET_PIN_N || WATCHDOG_WAKE || INTERRUPT_WAKE) begin
            nxt_state    = prs_pkg::ST_OST;
            nxt_ost_need = 1'b1;
            ost_clear    = 1'b1;
          end
        end
        default: begin
          nxt_state = prs_pkg::ST_POR;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff    <= prs_pkg::ST_POR;
      ost_need_ff <= 1'b1;
    end else if (CE) begin
      state_ff    <= nxt_state;
      ost_need_ff <= nxt_ost_need;
    end
  end

  // ==========================================================================
  // APB slave: one wait state, PREADY high for one cycle.
  // ==========================================================================
  always_comb begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (PADDR)
      prs_pkg::CFG_WORD_OFFSET: begin
        // The word is only visible while programming.
        if (PROGRAMMING_MODE) begin
          nxt_prdata = {18'h00000, cfg_word};
        end else begin
          nxt_pslverr = 1'b1;
        end
      end
      prs_pkg::STATUS_OFFSET: begin
        nxt_prdata = {26'h0000000, state_ff};
      end
      prs_pkg::CONTROL_OFFSET: begin
        nxt_prdata = {29'h00000000, cfg.bor_on, cfg.powerup_delay_timer_on, cfg.wdt_on};
      end
      default: begin
        nxt_pslverr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (CE) begin
      pready_ff  <= apb_fire;
      prdata_ff  <= (apb_fire && !PWRITE) ? nxt_prdata : 32'h0000_0000;
      pslverr_ff <= apb_fire ? nxt_pslverr : 1'b0;
    end
  end

  // ==========================================================================
  // Registered outputs.
  // ==========================================================================
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      core_rst_ff <= 1'b1;
      osc_ff      <= prs_pkg::MODE_RC;
      wdt_ff      <= 1'b0;
      sleep_ff    <= 1'b0;
      fetch_ff    <= prs_pkg::RESET_VECTOR;
    end else if (CE) begin
      core_rst_ff <= (nxt_state != prs_pkg::ST_RUN) && (nxt_state != prs_pkg::ST_SLEEP);
      osc_ff      <= cfg.osc_mode;
      // Software has no path to this bit; only the word controls it.
      wdt_ff      <= cfg.wdt_on;
      sleep_ff    <= (nxt_state == prs_pkg::ST_SLEEP);
      if (nxt_state != prs_pkg::ST_RUN && nxt_state != prs_pkg::ST_SLEEP) begin
        fetch_ff <= prs_pkg::RESET_VECTOR;
      end
    end
  end

  assign PRDATA       = prdata_ff;
  assign PREADY       = pready_ff;
  assign PSLVERR      = pslverr_ff;
  assign CORE_RESET   = core_rst_ff;
  assign FETCH_ADDR   = fetch_ff;
  assign OSC_MODE     = osc_ff;
  assign WATCHDOG_RUN = wdt_ff;
  assign SLEEPING     = sleep_ff;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  sequence s_run_to_reset;
    state_ff == prs_pkg::ST_RUN ##1 state_ff == prs_pkg::ST_POR;
  endsequence

  property p_por_reset;
    @(posedge CLOCK) disable iff (!RSTN)
    CE && POWER_ON_DETECT |=> state_ff == prs_pkg::ST_POR ##1 CORE_RESET;
  endproperty
  a_por_reset: assert property (p_por_reset) else $error("POR did not reset");

  property p_powerup_delay_timer_hold;
    @(posedge CLOCK) disable iff (!RSTN)
    state_ff == prs_pkg::ST_POWERUP_DELAY_TIMER |=> CORE_RESET;
  endproperty
  a_powerup_delay_timer_hold: assert property (p_powerup_delay_timer_hold) else $error("reset dropped in delay");

  property p_powerup_delay_timer_skip;
    @(posedge CLOCK) disable iff (!RSTN)
    CE && state_ff == prs_pkg::ST_POR && !POWER_ON_DETECT && !bor_trip && !cfg.powerup_delay_timer_on
      |=> state_ff == prs_pkg::ST_OST;
  endproperty
  a_powerup_delay_timer_skip: assert property (p_powerup_delay_timer_skip) else $error("disabled delay not skipped");

  property p_bor_enter;
    @(posedge CLOCK) disable iff (!RSTN)
    CE && bor_trip && !POWER_ON_DETECT |=> state_ff == prs_pkg::ST_BOR;
  endproperty
  a_bor_enter: assert property (p_bor_enter) else $error("brown-out not entered");

  property p_bor_disabled;
    @(posedge CLOCK) disable iff (!RSTN)
    !cfg.bor_on |=> bor_cnt_ff == 8'h00;
  endproperty
  a_bor_disabled: assert property (p_bor_disabled) else $error("disabled brown-out tripped");

  property p_bor_hold;
    @(posedge CLOCK) disable iff (!RSTN)
    CE && state_ff == prs_pkg::ST_BOR && BROWNOUT_DETECT && !POWER_ON_DETECT
      |=> state_ff == prs_pkg::ST_BOR;
  endproperty
  a_bor_hold: assert property (p_bor_hold) else $error("left brown-out early");

  property p_rc_no_ost;
    @(posedge CLOCK) disable iff (!RSTN)
    CE && state_ff == prs_pkg::ST_OST && cfg.osc_mode == prs_pkg::MODE_RC &&
      !POWER_ON_DETECT && !bor_trip && EXTERNAL_RESET_PIN_N |=> state_ff == prs_pkg::ST_RUN;
  endproperty
  a_rc_no_ost: assert property (p_rc_no_ost) else $error("RC mode waited");

  property p_cfg_locked;
    @(posedge CLOCK) disable iff (!RSTN)
    cfg_prog |-> PROGRAMMING_MODE;
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config written outside programming");

  property p_fetch_vector;
    @(posedge CLOCK) disable iff (!RSTN)
    $fell(CORE_RESET) |-> FETCH_ADDR == prs_pkg::RESET_VECTOR;
  endproperty
  a_fetch_vector: assert property (p_fetch_vector) else $error("bad reset vector");

  property p_wdt_cfg;
    @(posedge CLOCK) disable iff (!RSTN)
    CE ##1 CE |-> WATCHDOG_RUN == $past(cfg.wdt_on);
  endproperty
  a_wdt_cfg: assert property (p_wdt_cfg) else $error("watchdog not from config");

  property p_no_run_to_por;
    @(posedge CLOCK) disable iff (!RSTN)
    s_run_to_reset |-> $past(POWER_ON_DETECT);
  endproperty
  a_no_run_to_por: assert property (p_no_run_to_por) else $error("spurious power-up");

endmodule

// ==== tb.sv ====
// Self-checking bench for the power-up reset sequencer, driven over APB and its pins.
// Assumes prs_pkg and prs_sequencer are compiled first; delay and start-up counts are shortened to four, the brown-out filter to two.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and observation.
  // ==========================================================================
  localparam int PT = 4;
  localparam int OC = 4;
  localparam logic [15:0] CFGA = prs_pkg::CFG_WORD_OFFSET;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        pod = 1'b0;
  logic        bod = 1'b0;
  logic        ext_n = 1'b1;
  logic        rc = 1'b0;
  logic        osc = 1'b0;
  logic        slp = 1'b0;
  logic        wdw = 1'b0;
  logic        irw = 1'b0;
  logic        prog = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        core_rst;
  logic        wdt_run;
  logic        sleeping;
  logic [12:0] fetch;
  logic [1:0]  osc_mode;
  int          err_count = 0;
  int          n_tests = 0;

`define CHK(got, exp) \
  begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: value %0h, expected %0h", $time, got, exp); end end

  always #4 clock = ~clock;

  prs_sequencer #(.POWERUP_DELAY_TIMER_TICKS(PT), .OST_CYCLES(OC), .BOR_FILTER(2)) u_prs_sequencer (
    .CLOCK(clock), .RSTN(rstn), .CE(1'b1), .POWER_ON_DETECT(pod),
    .BROWNOUT_DETECT(bod), .EXTERNAL_RESET_PIN_N(ext_n), .RC_CLOCK(rc),
    .MAIN_CLOCK_INPUT_PIN(osc), .SLEEP_REQ(slp), .WATCHDOG_WAKE(wdw),
    .INTERRUPT_WAKE(irw), .PROGRAMMING_MODE(prog), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CORE_RESET(core_rst), .FETCH_ADDR(fetch),
    .OSC_MODE(osc_mode), .WATCHDOG_RUN(wdt_run), .SLEEPING(sleeping));

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic do_reset;
    rstn <= 1'b0;
    tick(8);
    rstn <= 1'b1;
    tick(2);
  endtask

  // Rising edges on the RC tick input or on the main oscillator pin.
  task automatic edges(input logic main, input int n);
    repeat (n) begin
      @(posedge clock);
      rc <= ~main;
      osc <= main;
      tick(2);
      rc <= 1'b0;
      osc <= 1'b0;
      tick(2);
    end
  endtask

  task automatic pulse_pod;
    @(posedge clock);
    pod <= 1'b1;
    @(posedge clock);
    pod <= 1'b0;
    tick(3);
  endtask

  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    pen <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic wait_run;
    int k = 0;
    while (core_rst !== 1'b0 && k < 100) begin
      tick(1);
      k++;
    end
    `CHK(core_rst, 1'b0)
    if (k >= 100) summarize();
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  initial begin
    do_reset();
    `CHK(core_rst, 1'b1)
    `CHK(osc_mode, prs_pkg::MODE_RC)
    `CHK(wdt_run, 1'b1)
    `CHK(fetch, prs_pkg::RESET_VECTOR)
    apb(1'b0, prs_pkg::STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0004)
    apb(1'b0, CFGA, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b0, 16'h0100, 32'h0000_0000);
    `CHK(err, 1'b1)
    pulse_pod();
    edges(1'b0, PT - 1);
    tick(4);
    `CHK(core_rst, 1'b1)
    edges(1'b0, 1);
    wait_run();
    `CHK(fetch, prs_pkg::RESET_VECTOR)
    apb(1'b1, prs_pkg::CONTROL_OFFSET, 32'h0000_0000);
    `CHK(err, 1'b0)
    apb(1'b0, prs_pkg::CONTROL_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0007)
    // A one-cycle dip is below the filter; a long one trips brown-out reset.
    bod <= 1'b1;
    tick(1);
    bod <= 1'b0;
    tick(6);
    `CHK(core_rst, 1'b0)
    bod <= 1'b1;
    tick(8);
    `CHK(core_rst, 1'b1)
    apb(1'b0, prs_pkg::STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    bod <= 1'b0;
    edges(1'b0, 2);
    bod <= 1'b1;
    tick(8);
    apb(1'b0, prs_pkg::STATUS_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    bod <= 1'b0;
    edges(1'b0, PT - 1);
    tick(4);
    `CHK(core_rst, 1'b1)
    edges(1'b0, 1);
    wait_run();
    for (int i = 0; i < 2; i++) begin
      slp <= 1'b1;
      tick(3);
      slp <= 1'b0;
      `CHK(sleeping, 1'b1)
      irw <= (i == 0);
      wdw <= (i == 1);
      tick(2);
      irw <= 1'b0;
      wdw <= 1'b0;
      wait_run();
      `CHK(sleeping, 1'b0)
    end
    ext_n <= 1'b0;
    tick(4);
    `CHK(core_rst, 1'b1)
    ext_n <= 1'b1;
    wait_run();
    // Crystal modes: delay disabled, start-up count on the main pin only.
    for (int m = 0; m < 3; m++) begin
      do_reset();
      prog <= 1'b1;
      apb(1'b1, CFGA, 32'h0000_3FF4 | m);
      apb(1'b0, CFGA, 32'h0000_0000);
      `CHK(rd, 32'h0000_3FF4 | m)
      `CHK(osc_mode, 2'(m))
      pulse_pod();
      edges(1'b1, OC - 1);
      tick(4);
      `CHK(core_rst, 1'b1)
      edges(1'b1, 1);
      wait_run();
    end
    apb(1'b1, CFGA, 32'h0000_3FB0);
    tick(2);
    `CHK(wdt_run, 1'b0)
    apb(1'b0, prs_pkg::CONTROL_OFFSET, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bod <= 1'b1;
    tick(8);
    `CHK(core_rst, 1'b0)
    bod <= 1'b0;
    prog <= 1'b0;
    apb(1'b1, CFGA, 32'h0000_0000);
    `CHK(err, 1'b1)
    prog <= 1'b1;
    apb(1'b0, CFGA, 32'h0000_0000);
    `CHK(rd, 32'h0000_3FB0)
    summarize();
  end
endmodule
